// File: fan_status_params.svh
/*
 * Register offsets, field positions, reset values and decode constants
 * for the fan status and automatic fan start/span register subset.
 * Assumes inclusion by bare name from the design module only.
 */
`ifndef FAN_STATUS_PARAMS_SVH
`define FAN_STATUS_PARAMS_SVH

// ============================================================
// Register offsets
`define ADDR_FAN_TEMP_STATUS        8'h02
`define ADDR_LOCAL_TEMP_OFFSET      8'h0d
`define ADDR_LOCAL_AUTOFAN_SPAN     8'h24
`define ADDR_REMOTE_AUTOFAN_SPAN    8'h25

// ============================================================
// Reset values
`define RST_FAN_TEMP_STATUS         8'h00
`define RST_LOCAL_TEMP_OFFSET       8'h00
`define RST_LOCAL_AUTOFAN_SPAN      8'h41
`define RST_REMOTE_AUTOFAN_SPAN     8'h61

// ============================================================
// Status bit positions
`define BIT_ALARM_SPEED             0
`define BIT_FAN_FAULT               1
`define BIT_REMOTE_HIGH             2

// ============================================================
// Start field <7:3> in 4-degree steps, span field <2:0>
`define START_MSB                   7
`define START_LSB                   3
`define SPAN_MSB                    2
`define SPAN_LSB                    0
`define SPAN_CODE_5C                3'h0
`define SPAN_CODE_10C               3'h1
`define SPAN_CODE_20C               3'h2
`define SPAN_CODE_40C               3'h3
`define SPAN_CODE_80C               3'h4
`define SPAN_5C                     8'h05
`define SPAN_10C                    8'h0a
`define SPAN_20C                    8'h14
`define SPAN_40C                    8'h28
`define SPAN_80C                    8'h50

`endif

// File: fan_status_pkg.sv
/*
 * Types shared by the fan status register block.
 * Assumes the parameter header is on the include path.
 */
package fan_status_pkg;

    // ============================================================
    // Host register access, one request per cycle
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_t;

    // ============================================================
    // Monitoring-cycle inputs from the measurement logic
    typedef struct packed {
        logic       tick;
        logic       fan_at_alarm;
        logic       fan_failed;
        logic [7:0] remote_temp;
        logic [7:0] remote_high_limit;
    } mon_in_t;

    // ============================================================
    // Decoded automatic control settings, degrees C
    typedef struct packed {
        logic [7:0] start_c;
        logic [7:0] span_c;
        logic [8:0] full_c;
    } autofan_t;

endpackage

// File: fan_status_regs.sv
/*
 * Fan status flags, local/remote automatic fan start and span registers
 * and the local temperature offset register, with host register access.
 * Assumes the serial host link is decoded elsewhere into one-cycle read
 * and write strobes on I_CLK, and that monitoring inputs are on I_CLK.
 */
// Functional notes
// - Status bit 0 is set when the fan is driven at alarm speed.
// - Once status bit 0 is read it is not set again on the next monitoring cycle.
// - Status bit 1 is set when the fan is stalled or under speed.
// - Once status bit 1 is read it is set again on the next monitoring cycle if the fault remains.
// - Status bit 2 is set when the remote temperature exceeds its high limit.
// - The status register at 0x02 is read-only and resets to all zeros.
// - Local start temperature is bits 7..3 in 4-degree steps, 0 to 124 degrees.
// - Local span bits 2..0 decode 0..4 to 5, 10, 20, 40 and 80 degrees.
// - Register 0x24 is read/write and resets to 0x41.
// - Bits 7..3 of register 0x25 hold the remote-driven start temperature.
// - The local offset register at 0x0d resets to zero.
`timescale 1ns/1ps
`include "fan_status_params.svh"

module fan_status_regs
    import fan_status_pkg::*;
(
    input  wire logic     I_CLK,
    input  wire logic     I_RST,
    input  wire reg_req_t I_REG_REQ,
    input  wire mon_in_t  I_MON,
    output logic [7:0]    O_REG_RDATA,
    output logic [7:0]    O_LOCAL_OFFSET,
    output autofan_t      O_LOCAL_AUTOFAN,
    output autofan_t      O_REMOTE_AUTOFAN
);

    // ============================================================
    // Span decode; codes above 4 saturate at the widest span
    function automatic logic [7:0] span_decode(input logic [2:0] code);
        logic [7:0] r;
        unique case (code)
            `SPAN_CODE_5C:  r = `SPAN_5C;
            `SPAN_CODE_10C: r = `SPAN_10C;
            `SPAN_CODE_20C: r = `SPAN_20C;
            `SPAN_CODE_40C: r = `SPAN_40C;
            default:        r = `SPAN_80C;
        endcase
        return r;
    endfunction

    // Start code times four, full-drive point is start plus span
    function automatic autofan_t autofan_decode(input logic [7:0] r);
        autofan_t a;
        a.start_c = {r[`START_MSB:`START_LSB], 3'h0} >> 1;
        a.span_c  = span_decode(r[`SPAN_MSB:`SPAN_LSB]);
        a.full_c  = {1'b0, a.start_c} + {1'b0, a.span_c};
        return a;
    endfunction

    // ============================================================
    // Register state
    logic [2:0] status_q, status_d;
    logic       alarm_hold_q, alarm_hold_d;
    logic [7:0] offset_q, offset_d;
    logic [7:0] local_q, local_d;
    logic [7:0] remote_q, remote_d;
    logic [7:0] rdata_q, rdata_d;
    autofan_t   local_af_q, local_af_d;
    autofan_t   remote_af_q, remote_af_d;

    logic status_rd;
    logic set_alarm;
    logic set_fault;
    logic set_remote;
    logic remote_over;

    // Temperatures are two's complement
    assign remote_over = $signed(I_MON.remote_temp) > $signed(I_MON.remote_high_limit);
    assign status_rd   = I_REG_REQ.rd && (I_REG_REQ.addr == `ADDR_FAN_TEMP_STATUS);
    assign set_alarm   = I_MON.tick && I_MON.fan_at_alarm && !alarm_hold_q;
    assign set_fault   = I_MON.tick && I_MON.fan_failed;
    assign set_remote  = I_MON.tick && remote_over;

    // ============================================================
    // Status flags: read clears, a set in the same cycle wins
    always_comb begin
        status_d = status_q;
        alarm_hold_d = alarm_hold_q;
        if (status_rd) begin
            status_d = 3'h0;
            // Hold off re-assertion only if the host saw the flag
            if (status_q[`BIT_ALARM_SPEED]) begin
                alarm_hold_d = 1'b1;
            end
        end
        // Hold-off ends once a monitoring cycle finds the fan off alarm speed
        if (I_MON.tick && !I_MON.fan_at_alarm) begin
            alarm_hold_d = 1'b0;
        end
        if (set_alarm) begin
            status_d[`BIT_ALARM_SPEED] = 1'b1;
        end
        if (set_fault) begin
            status_d[`BIT_FAN_FAULT] = 1'b1;
        end
        if (set_remote) begin
            status_d[`BIT_REMOTE_HIGH] = 1'b1;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            status_q     <= 3'h0;
            alarm_hold_q <= 1'b0;
        end else begin
            status_q     <= status_d;
            alarm_hold_q <= alarm_hold_d;
        end
    end

    // ============================================================
    // Writable registers; writes to the status offset are dropped
    always_comb begin
        offset_d = offset_q;
        local_d  = local_q;
        remote_d = remote_q;
        if (I_REG_REQ.wr) begin
            unique case (I_REG_REQ.addr)
                `ADDR_LOCAL_TEMP_OFFSET:   offset_d = I_REG_REQ.wdata;
                `ADDR_LOCAL_AUTOFAN_SPAN:  local_d  = I_REG_REQ.wdata;
                `ADDR_REMOTE_AUTOFAN_SPAN: remote_d = I_REG_REQ.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            offset_q <= `RST_LOCAL_TEMP_OFFSET;
            local_q  <= `RST_LOCAL_AUTOFAN_SPAN;
            remote_q <= `RST_REMOTE_AUTOFAN_SPAN;
        end else begin
            offset_q <= offset_d;
            local_q  <= local_d;
            remote_q <= remote_d;
        end
    end

    // ============================================================
    // Read data, registered; unmapped offsets read zero
    always_comb begin
        rdata_d = rdata_q;
        if (I_REG_REQ.rd) begin
            unique case (I_REG_REQ.addr)
                `ADDR_FAN_TEMP_STATUS:     rdata_d = {5'h00, status_q};
                `ADDR_LOCAL_TEMP_OFFSET:   rdata_d = offset_q;
                `ADDR_LOCAL_AUTOFAN_SPAN:  rdata_d = local_q;
                `ADDR_REMOTE_AUTOFAN_SPAN: rdata_d = remote_q;
                default:                   rdata_d = 8'h00;
            endcase
        end
    end

    // ============================================================
    // Decoded settings for the control loop, one cycle behind the registers
    always_comb begin
        local_af_d  = autofan_decode(local_q);
        remote_af_d = autofan_decode(remote_q);
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            rdata_q     <= 8'h00;
            local_af_q  <= autofan_decode(`RST_LOCAL_AUTOFAN_SPAN);
            remote_af_q <= autofan_decode(`RST_REMOTE_AUTOFAN_SPAN);
        end else begin
            rdata_q     <= rdata_d;
            local_af_q  <= local_af_d;
            remote_af_q <= remote_af_d;
        end
    end

    assign O_REG_RDATA      = rdata_q;
    assign O_LOCAL_OFFSET   = offset_q;
    assign O_LOCAL_AUTOFAN  = local_af_q;
    assign O_REMOTE_AUTOFAN = remote_af_q;

    // ============================================================
    // Checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    property p_alarm_set;
        I_MON.tick && I_MON.fan_at_alarm && !alarm_hold_q |=> status_q[`BIT_ALARM_SPEED];
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set");

    property p_alarm_hold;
        status_rd && status_q[`BIT_ALARM_SPEED] && !I_MON.tick
            ##1 !I_MON.tick && !status_rd
            ##1 I_MON.tick && I_MON.fan_at_alarm && !status_rd
            |=> !status_q[`BIT_ALARM_SPEED];
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm flag reasserted");

    property p_fault_set;
        I_MON.tick && I_MON.fan_failed |=> status_q[`BIT_FAN_FAULT];
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault flag not set");

    property p_fault_again;
        status_rd && !I_MON.tick ##1 !I_MON.tick ##1 I_MON.tick && I_MON.fan_failed
            |=> status_q[`BIT_FAN_FAULT];
    endproperty
    a_fault_again: assert property (p_fault_again) else $error("fault not reasserted");

    property p_remote_set;
        I_MON.tick && ($signed(I_MON.remote_temp) > $signed(I_MON.remote_high_limit))
            |=> status_q[`BIT_REMOTE_HIGH];
    endproperty
    a_remote_set: assert property (p_remote_set) else $error("remote flag not set");

    property p_status_ro;
        I_REG_REQ.wr && !I_REG_REQ.rd && !I_MON.tick |=> status_q == $past(status_q);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status changed by write");

    property p_local_start;
        ##1 O_LOCAL_AUTOFAN.start_c == {1'b0, $past(local_q[7:3]), 2'b00};
    endproperty
    a_local_start: assert property (p_local_start) else $error("local start wrong");

    property p_local_span;
        local_q[2:0] == `SPAN_CODE_40C |=> O_LOCAL_AUTOFAN.span_c == `SPAN_40C;
    endproperty
    a_local_span: assert property (p_local_span) else $error("local span wrong");

    property p_local_wr;
        I_REG_REQ.wr && I_REG_REQ.addr == `ADDR_LOCAL_AUTOFAN_SPAN
            |=> local_q == $past(I_REG_REQ.wdata);
    endproperty
    a_local_wr: assert property (p_local_wr) else $error("local write lost");

    property p_remote_start;
        ##1 O_REMOTE_AUTOFAN.start_c == {1'b0, $past(remote_q[7:3]), 2'b00};
    endproperty
    a_remote_start: assert property (p_remote_start) else $error("remote start wrong");

    property p_offset_rst;
        disable iff (1'b0) I_RST |=> offset_q == 8'h00 && local_q == `RST_LOCAL_AUTOFAN_SPAN;
    endproperty
    a_offset_rst: assert property (p_offset_rst) else $error("reset value wrong");

    property p_full_point;
        ##1 O_LOCAL_AUTOFAN.full_c
            == {2'b00, $past(local_q[7:3]), 2'b00} + {1'b0, O_LOCAL_AUTOFAN.span_c};
    endproperty
    a_full_point: assert property (p_full_point) else $error("full point wrong");

    // ============================================================
    // Further status checks: read answer, read-clear, stickiness
    property p_read_status;
        status_rd |=> O_REG_RDATA == {5'h00, $past(status_q)};
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read data wrong");

    property p_read_clear;
        status_rd && !I_MON.tick |=> status_q == 3'h0;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status not cleared");

    // Flags only move on a monitoring tick or a status read
    property p_status_sticky;
        !I_MON.tick && !status_rd |=> status_q == $past(status_q);
    endproperty
    a_status_sticky: assert property (p_status_sticky) else $error("status flag moved");

    // ============================================================
    // Further register and decode checks
    property p_offset_wr;
        I_REG_REQ.wr && I_REG_REQ.addr == `ADDR_LOCAL_TEMP_OFFSET
            |=> offset_q == $past(I_REG_REQ.wdata);
    endproperty
    a_offset_wr: assert property (p_offset_wr) else $error("offset write lost");

    property p_remote_wr;
        I_REG_REQ.wr && I_REG_REQ.addr == `ADDR_REMOTE_AUTOFAN_SPAN
            |=> remote_q == $past(I_REG_REQ.wdata);
    endproperty
    a_remote_wr: assert property (p_remote_wr) else $error("remote write lost");

    // Narrowest and widest span ends of the decode
    property p_local_span_min;
        local_q[2:0] == `SPAN_CODE_5C |=> O_LOCAL_AUTOFAN.span_c == `SPAN_5C;
    endproperty
    a_local_span_min: assert property (p_local_span_min) else $error("narrow span wrong");

    property p_local_span_max;
        local_q[2:0] == `SPAN_CODE_80C |=> O_LOCAL_AUTOFAN.span_c == `SPAN_80C;
    endproperty
    a_local_span_max: assert property (p_local_span_max) else $error("wide span wrong");

    property p_remote_span;
        remote_q[2:0] == `SPAN_CODE_20C |=> O_REMOTE_AUTOFAN.span_c == `SPAN_20C;
    endproperty
    a_remote_span: assert property (p_remote_span) else $error("remote span wrong");

    property p_remote_full;
        ##1 O_REMOTE_AUTOFAN.full_c
            == {2'b00, $past(remote_q[7:3]), 2'b00} + {1'b0, O_REMOTE_AUTOFAN.span_c};
    endproperty
    a_remote_full: assert property (p_remote_full) else $error("remote full point wrong");

    c_alarm_hold: cover property (status_rd && status_q[`BIT_ALARM_SPEED] ##1 alarm_hold_q);
    c_fault_again: cover property (status_rd ##1 I_MON.tick && I_MON.fan_failed);
    c_local_write: cover property (I_REG_REQ.wr && I_REG_REQ.addr == `ADDR_LOCAL_AUTOFAN_SPAN);
    c_remote_high: cover property (I_MON.tick && remote_over ##1 status_q[`BIT_REMOTE_HIGH]);
    c_set_on_read: cover property (status_rd && I_MON.tick && I_MON.fan_failed);

endmodule

// File: smbus_host_model.sv
/*
 * Host-side model: issues register reads and writes on the strobe port.
 * Assumes the SMBus framing is already decoded into one-cycle rd/wr
 * strobes on the block clock, with read data one cycle after the strobe.
 */
`timescale 1ns/1ps

module smbus_host_model
    import fan_status_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output reg_req_t        o_req
);
    // ============================================================
    // Idle request at time zero
    initial begin
        o_req = '0;
    end

    // Write strobe for one edge, then address and data are scrambled
    // so that the block cannot rely on values left standing
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        o_req <= '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
        @(posedge i_clk);
        o_req <= '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~data};
    endtask

    // Read strobe for one edge; data is taken once that edge settles
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge i_clk);
        o_req <= '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge i_clk);
        o_req <= '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
        #1;
        data = i_rdata;
    endtask
endmodule

// File: tb_top.sv
/*
 * Self-checking bench for the fan status and autofan register block.
 * Assumes the host model drives the register port and the bench itself
 * plays the measurement logic on the monitoring inputs.
 */
`timescale 1ns/1ps

module tb_top
    import fan_status_pkg::*;
;
    logic       I_CLK;
    logic       I_RST;
    reg_req_t   req;
    mon_in_t    mon;
    logic [7:0] rdata;
    logic [7:0] offset;
    autofan_t   loc_af;
    autofan_t   rem_af;
    logic [7:0] rd;
    int         error_cnt = 0;
    int         checks    = 0;
    int         cyc       = 0;
    logic [7:0] span_tab [8] = '{8'h05, 8'h0a, 8'h14, 8'h28, 8'h50, 8'h50, 8'h50, 8'h50};

    // ============================================================
    // Design and host
    fan_status_regs i_dut (
        .I_CLK            (I_CLK),
        .I_RST            (I_RST),
        .I_REG_REQ        (req),
        .I_MON            (mon),
        .O_REG_RDATA      (rdata),
        .O_LOCAL_OFFSET   (offset),
        .O_LOCAL_AUTOFAN  (loc_af),
        .O_REMOTE_AUTOFAN (rem_af)
    );

    smbus_host_model i_host (
        .i_clk   (I_CLK),
        .i_rdata (rdata),
        .o_req   (req)
    );

    // ============================================================
    // Clock, 40 ns period
    initial begin
        I_CLK = 1'b0;
        forever #20 I_CLK = ~I_CLK;
    end

    // Hang guard, well above the about 125 cycles the run needs
    always @(posedge I_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            print_verdict();
        end
    end

    // ============================================================
    // Shared tasks
    task automatic check(input string name, input logic [24:0] seen, input logic [24:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // One monitoring cycle; levels stay until the next tick
    task automatic tick(input logic alarm, input logic failed, input logic [7:0] temp);
        @(posedge I_CLK);
        mon <= '{tick: 1'b1, fan_at_alarm: alarm, fan_failed: failed,
                 remote_temp: temp, remote_high_limit: 8'h4f};
        @(posedge I_CLK);
        mon.tick <= 1'b0;
    endtask

    task automatic rd_status(input logic [7:0] exp);
        i_host.read_reg(8'h02, rd);
        check("status", {17'h0, rd}, {17'h0, exp});
    endtask

    task automatic print_verdict();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        I_RST = 1'b1;
        mon   = '0;
        repeat (10) @(posedge I_CLK);
        I_RST <= 1'b0;
        // Power-on values, unmapped read included
        i_host.read_reg(8'h0d, rd);
        check("offset_rst", {17'h0, rd}, 25'h0);
        i_host.read_reg(8'h24, rd);
        check("local_rst", {17'h0, rd}, 25'h41);
        i_host.read_reg(8'h25, rd);
        check("remote_rst", {17'h0, rd}, 25'h61);
        i_host.read_reg(8'h30, rd);
        check("unmapped", {17'h0, rd}, 25'h0);
        rd_status(8'h00);
        check("local_af_rst", loc_af, {8'h20, 8'h0a, 9'h02a});
        check("remote_af_rst", rem_af, {8'h30, 8'h0a, 9'h03a});
        // Status is not writable
        i_host.write_reg(8'h02, 8'hff);
        rd_status(8'h00);
        // Fan fault: set, read-clear, reasserts while failed
        tick(1'b0, 1'b1, 8'h00);
        rd_status(8'h02);
        rd_status(8'h00);
        tick(1'b0, 1'b1, 8'h00);
        rd_status(8'h02);
        // Alarm speed: held off after a read until the fan leaves alarm
        tick(1'b1, 1'b0, 8'h00);
        rd_status(8'h01);
        tick(1'b1, 1'b0, 8'h00);
        rd_status(8'h00);
        tick(1'b0, 1'b0, 8'h00);
        tick(1'b1, 1'b0, 8'h00);
        rd_status(8'h01);
        // Remote high: strictly above, signed; limit is 0x4f
        tick(1'b0, 1'b0, 8'h50);
        rd_status(8'h04);
        tick(1'b0, 1'b0, 8'h4f);
        rd_status(8'h00);
        tick(1'b0, 1'b0, 8'hf0);
        rd_status(8'h00);
        // Fault tick in the very cycle of a status read: the set wins
        fork
            tick(1'b0, 1'b1, 8'h00);
            i_host.read_reg(8'h02, rd);
        join
        check("status_race", {17'h0, rd}, 25'h0);
        rd_status(8'h02);
        // Every span code at the top start value; codes above 4 saturate
        for (int c = 0; c < 8; c++) begin
            i_host.write_reg(8'h24, {5'h1f, 3'(c)});
            repeat (2) @(posedge I_CLK);
            #1;
            check("local_af", loc_af, {8'h7c, span_tab[c], 9'd124 + 9'(span_tab[c])});
            i_host.read_reg(8'h24, rd);
            check("local_rb", {17'h0, rd}, {17'h0, 5'h1f, 3'(c)});
        end
        // Lowest start, then the remote pair and the offset
        i_host.write_reg(8'h24, 8'h00);
        i_host.write_reg(8'h25, {5'h03, 3'h2});
        i_host.write_reg(8'h0d, 8'ha5);
        repeat (2) @(posedge I_CLK);
        #1;
        check("local_af0", loc_af, {8'h00, 8'h05, 9'h005});
        check("remote_af", rem_af, {8'h0c, 8'h14, 9'h020});
        check("offset_out", {17'h0, offset}, 25'ha5);
        i_host.read_reg(8'h25, rd);
        check("remote_rb", {17'h0, rd}, 25'h1a);
        i_host.read_reg(8'h0d, rd);
        check("offset_rb", {17'h0, rd}, 25'ha5);
        print_verdict();
    end
endmodule
